// ==== design/analog_comparator_control.sv ====
// Control, status and interrupt logic around the second analog comparator.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// (RULE1) The raw comparator result is high when the selected positive input exceeds the negative one.
// (RULE2) Setting the power-off bit removes power from the comparator core.
// (RULE3) The bandgap bit picks the positive pin when 0 and the bandgap reference when 1.
// (RULE4) The output status bit is the result after a synchronizer of one to two cycles.
// (RULE5) The interrupt flag sets when a synchronized output change matches the selected mode.
// (RULE6) The flag clears on vector execution or when software writes one to it.
// (RULE7) The request is issued only while the interrupt enable and global enable are both set.
// (RULE8) The capture-route bit connects the synchronized output to the timer capture front end.
// (RULE9) Mode 00 is toggle, 01 reserved, 10 falling edge and 11 rising edge.
// (RULE10) Software disables the interrupt before changing the mode or the power-off bit.
// (RULE11) Hysteresis select enables hysteresis and the level bit picks 20 mV or 50 mV.
// (RULE12) The output-enable bit drives the result onto the comparator output pin.
// (RULE13) The negative input is the converter multiplexer only when mux enable is 1 and converter off.
// (RULE14) Reserved bits 5, 3, 1 and 0 of the input configuration register read zero.
// (RULE15) Input-disable bits 4 and 3 turn off the negative and positive pin buffers, reading zero.
// (RULE16) Edges are found by comparing the synchronized output with its previous value.
module analog_comparator_control (
  input  wire logic                            mclk,
  input  wire logic                            srst,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic                            cmp_raw,
  input  wire logic                            converter_enable,
  input  wire logic                            cmp_pos_pin_digital,
  input  wire logic                            cmp_neg_pin_digital,
  output logic                                 cmp_pos_pin_read,
  output logic                                 cmp_neg_pin_read,
  output cmp_ctrl_pkg::analog_ctrl_type        analog_ctrl,
  output cmp_ctrl_pkg::route_type              route,
  output logic                                 cmp_irq_request,
  output logic                                 irq
);

  // Software-visible state.
  logic                 cmp_power_off_q;
  logic                 cmp_bandgap_select_q;
  logic                 cmp_irq_enable_q;
  logic                 cmp_capture_route_q;
  logic [1:0]           cmp_irq_mode_q;
  logic                 cmp_irq_flag_q;
  logic                 hysteresis_select_q;
  logic                 hysteresis_level_q;
  logic                 cmp_pin_output_enable_q;
  logic                 cmp_mux_enable_q;
  logic                 neg_pin_input_disable_q;
  logic                 pos_pin_input_disable_q;
  logic                 gie_q;
  logic [cmp_ctrl_pkg::EV_W-1:0] ev_status_q;
  logic [cmp_ctrl_pkg::EV_W-1:0] ev_mask_q;
  logic [1:0]           sync_q;
  logic                 prev_q;

  // Bus decode.
  logic                 acc;
  logic                 wr;
  logic                 wr_ctrl;
  logic                 wr_cfg;
  logic                 wr_didr;
  logic                 wr_stat;
  logic                 wr_mask;
  logic                 wr_ext;
  logic                 sync_out;
  logic                 rise;
  logic                 fall;
  logic                 mode_hit;
  logic                 vec_ack;
  logic                 flag_clear;
  logic [31:0]          rd_d;

  // Low byte lane carries every register; other lanes are ignored on write.
  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign wr_ctrl = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_CTRL_STATUS);
  assign wr_cfg  = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_INPUT_CFG);
  assign wr_didr = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_DIDR);
  assign wr_stat = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_IRQ_STATUS);
  assign wr_mask = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_IRQ_MASK);
  assign wr_ext  = wr && (wb_adr_i == cmp_ctrl_pkg::OFF_CTRL_EXT);

  // Edge detection against the previous synchronized sample.
  assign sync_out = sync_q[1]; // [RULE4]
  assign rise     = sync_out && !prev_q; // [RULE16]
  assign fall     = !sync_out && prev_q; // [RULE16]

  // Mode decode; the reserved code never fires.
  always_comb begin
    unique case (cmp_ctrl_pkg::irq_mode_type'(cmp_irq_mode_q)) // [RULE9]
      cmp_ctrl_pkg::MODE_TOGGLE:   mode_hit = rise || fall;
      cmp_ctrl_pkg::MODE_RESERVED: mode_hit = 1'b0;
      cmp_ctrl_pkg::MODE_FALL:     mode_hit = fall;
      cmp_ctrl_pkg::MODE_RISE:     mode_hit = rise;
    endcase
  end

  assign vec_ack    = wr_ext && wb_dat_i[cmp_ctrl_pkg::BIT_VEC_ACK];
  assign flag_clear = vec_ack || (wr_ctrl && wb_dat_i[cmp_ctrl_pkg::BIT_IRQ_FLAG]);

  // Two-stage synchronizer on the raw result, then the previous-value register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_q <= cmp_ctrl_pkg::RST_SYNC;
      prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], cmp_raw}; // [RULE1] [RULE4]
      prev_q <= sync_q[1]; // [RULE16]
    end
  end

  // Control/status register; the flag set wins over a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_power_off_q      <= 1'b0;
      cmp_bandgap_select_q <= 1'b0;
      cmp_irq_enable_q     <= 1'b0;
      cmp_capture_route_q  <= 1'b0;
      cmp_irq_mode_q       <= 2'h0;
      cmp_irq_flag_q       <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cmp_power_off_q      <= wb_dat_i[cmp_ctrl_pkg::BIT_POWER_OFF]; // [RULE2]
        cmp_bandgap_select_q <= wb_dat_i[cmp_ctrl_pkg::BIT_BANDGAP]; // [RULE3]
        cmp_irq_enable_q     <= wb_dat_i[cmp_ctrl_pkg::BIT_IRQ_ENABLE];
        cmp_capture_route_q  <= wb_dat_i[cmp_ctrl_pkg::BIT_CAPTURE];
        cmp_irq_mode_q       <= wb_dat_i[cmp_ctrl_pkg::BIT_MODE_HI:cmp_ctrl_pkg::BIT_MODE_LO];
      end
      if (mode_hit) begin
        cmp_irq_flag_q <= 1'b1; // [RULE5]
      end else if (flag_clear) begin
        cmp_irq_flag_q <= 1'b0; // [RULE6]
      end
    end
  end

  // Input configuration, input-disable and global enable registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      hysteresis_select_q     <= 1'b0;
      hysteresis_level_q      <= 1'b0;
      cmp_pin_output_enable_q <= 1'b0;
      cmp_mux_enable_q        <= 1'b0;
      neg_pin_input_disable_q <= 1'b0;
      pos_pin_input_disable_q <= 1'b0;
      gie_q                   <= 1'b0;
    end else begin
      if (wr_cfg) begin
        hysteresis_select_q     <= wb_dat_i[cmp_ctrl_pkg::BIT_HYST_SEL]; // [RULE11]
        hysteresis_level_q      <= wb_dat_i[cmp_ctrl_pkg::BIT_HYST_LEV];
        cmp_pin_output_enable_q <= wb_dat_i[cmp_ctrl_pkg::BIT_PIN_OE];
        cmp_mux_enable_q        <= wb_dat_i[cmp_ctrl_pkg::BIT_MUX_EN];
      end
      if (wr_didr) begin
        neg_pin_input_disable_q <= wb_dat_i[cmp_ctrl_pkg::BIT_NEG_DIS]; // [RULE15]
        pos_pin_input_disable_q <= wb_dat_i[cmp_ctrl_pkg::BIT_POS_DIS];
      end
      if (wr_ext) begin
        gie_q <= wb_dat_i[cmp_ctrl_pkg::BIT_GIE];
      end
    end
  end

  // Sticky event bits; a new event beats a write-one clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ev_status_q <= '0;
      ev_mask_q   <= cmp_ctrl_pkg::RST_MASK[cmp_ctrl_pkg::EV_W-1:0];
    end else begin
      ev_status_q <= (ev_status_q & ~(wr_stat ? wb_dat_i[cmp_ctrl_pkg::EV_W-1:0] : '0))
                     | {mode_hit, fall, rise};
      if (wr_mask) begin
        ev_mask_q <= wb_dat_i[cmp_ctrl_pkg::EV_W-1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge.
  always_comb begin
    rd_d = cmp_ctrl_pkg::UNMAPPED;
    unique case (wb_adr_i)
      cmp_ctrl_pkg::OFF_CTRL_STATUS: rd_d[7:0] = {cmp_power_off_q, cmp_bandgap_select_q,
                                                   sync_out, cmp_irq_flag_q, cmp_irq_enable_q,
                                                   cmp_capture_route_q, cmp_irq_mode_q};
      cmp_ctrl_pkg::OFF_INPUT_CFG:   rd_d[7:0] = {hysteresis_select_q, hysteresis_level_q, 1'b0,
                                                   cmp_pin_output_enable_q, 1'b0,
                                                   cmp_mux_enable_q, 2'h0}; // [RULE14]
      cmp_ctrl_pkg::OFF_DIDR:        rd_d[7:0] = {3'h0, neg_pin_input_disable_q,
                                                   pos_pin_input_disable_q, 3'h0};
      cmp_ctrl_pkg::OFF_IRQ_STATUS:  rd_d[cmp_ctrl_pkg::EV_W-1:0] = ev_status_q;
      cmp_ctrl_pkg::OFF_IRQ_MASK:    rd_d[cmp_ctrl_pkg::EV_W-1:0] = ev_mask_q;
      cmp_ctrl_pkg::OFF_CTRL_EXT:    rd_d[0] = gie_q;
      default:                       rd_d = cmp_ctrl_pkg::UNMAPPED;
    endcase
  end

  // Single-wait-state slave: ack one cycle after the strobe, dropped the next cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_d : '0;
    end
  end

  // Registered outputs to the analog core, pins, timer and interrupt controller.
  always_ff @(posedge mclk) begin
    if (srst) begin
      analog_ctrl      <= '0;
      route            <= '0;
      cmp_irq_request  <= 1'b0;
      irq              <= 1'b0;
      cmp_pos_pin_read <= 1'b0;
      cmp_neg_pin_read <= 1'b0;
    end else begin
      analog_ctrl.power_off       <= cmp_power_off_q; // [RULE2]
      analog_ctrl.pos_bandgap     <= cmp_bandgap_select_q; // [RULE3]
      analog_ctrl.neg_adc_mux     <= cmp_mux_enable_q && !converter_enable; // [RULE13]
      analog_ctrl.hyst_enable     <= hysteresis_select_q; // [RULE11]
      // Level is forced low while hysteresis is off so the core sees no stray setting.
      analog_ctrl.hyst_level_high <= hysteresis_select_q && hysteresis_level_q; // [RULE11]
      analog_ctrl.neg_pin_input_disable <= neg_pin_input_disable_q; // [RULE15]
      analog_ctrl.pos_pin_input_disable <= pos_pin_input_disable_q; // [RULE15]
      route.capture_in     <= cmp_capture_route_q && sync_out; // [RULE8]
      route.capture_route  <= cmp_capture_route_q; // [RULE8]
      route.pin_out        <= cmp_pin_output_enable_q && sync_out; // [RULE12]
      route.pin_out_enable <= cmp_pin_output_enable_q; // [RULE12]
      cmp_irq_request  <= cmp_irq_flag_q && cmp_irq_enable_q && gie_q; // [RULE7]
      irq              <= |(ev_status_q & ev_mask_q);
      cmp_pos_pin_read <= cmp_pos_pin_digital && !pos_pin_input_disable_q; // [RULE15]
      cmp_neg_pin_read <= cmp_neg_pin_digital && !neg_pin_input_disable_q; // [RULE15]
    end
  end

endmodule // analog_comparator_control

// ==== design/cmp_ctrl_pkg.sv ====
// Package with register map, field layouts and carriers for the comparator control block.
package cmp_ctrl_pkg;

  // Register offsets as byte addresses; only the control/status offset is fixed by the map.
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INPUT_CFG   = 8'h10;
  localparam logic [7:0] OFF_DIDR        = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h1C;
  localparam logic [7:0] OFF_CTRL_EXT    = 8'h20;

  // Control/status register field positions.
  localparam int BIT_POWER_OFF  = 7;
  localparam int BIT_BANDGAP    = 6;
  localparam int BIT_SYNC_OUT   = 5;
  localparam int BIT_IRQ_FLAG   = 4;
  localparam int BIT_IRQ_ENABLE = 3;
  localparam int BIT_CAPTURE    = 2;
  localparam int BIT_MODE_HI    = 1;
  localparam int BIT_MODE_LO    = 0;

  // Input configuration register field positions.
  localparam int BIT_HYST_SEL = 7;
  localparam int BIT_HYST_LEV = 6;
  localparam int BIT_PIN_OE   = 4;
  localparam int BIT_MUX_EN   = 2;

  // Digital input disable field positions.
  localparam int BIT_NEG_DIS = 4;
  localparam int BIT_POS_DIS = 3;

  // Event status register bits (sticky, write one to clear).
  localparam int EV_RISE = 0;
  localparam int EV_FALL = 1;
  localparam int EV_FLAG = 2;
  localparam int EV_W    = 3;

  // Extension register: global interrupt enable and vector acknowledge.
  localparam int BIT_GIE     = 0;
  localparam int BIT_VEC_ACK = 1;

  // Reset values.
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_DIDR  = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [1:0] RST_SYNC  = 2'h0;
  localparam logic [31:0] UNMAPPED = 32'h0000_0000;

  // Hysteresis figures in millivolts.
  localparam int HYST_LOW_MV  = 20;
  localparam int HYST_HIGH_MV = 50;

  // Interrupt mode encodings.
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL     = 2'h2,
    MODE_RISE     = 2'h3
  } irq_mode_type;

  // Analog front-end controls carried together to the comparator core.
  typedef struct packed {
    logic power_off;
    logic pos_bandgap;
    logic neg_adc_mux;
    logic hyst_enable;
    logic hyst_level_high;
    logic neg_pin_input_disable;
    logic pos_pin_input_disable;
  } analog_ctrl_type;

  // Routed outputs of the synchronized result.
  typedef struct packed {
    logic capture_in;
    logic capture_route;
    logic pin_out;
    logic pin_out_enable;
  } route_type;

endpackage

// ==== tb/cmp_core_model.sv ====
// Behavioural model of the analog comparator core behind the control block.
`timescale 1ns/1ns
module cmp_core_model #(
  parameter int BANDGAP_MV = 1000
) (
  input wire cmp_ctrl_pkg::analog_ctrl_type analog_ctrl,
  input wire logic [15:0]                   pos_mv,
  input wire logic [15:0]                   neg_mv,
  input wire logic [15:0]                   mux_mv,
  output logic                              cmp_raw
);
  logic [15:0] pos_sel;
  logic [15:0] neg_sel;

  // Input selection and compare; an unpowered core gives a low output, not the last value.
  always_comb begin
    pos_sel = analog_ctrl.pos_bandgap ? 16'(BANDGAP_MV) : pos_mv;
    neg_sel = analog_ctrl.neg_adc_mux ? mux_mv : neg_mv;
    cmp_raw = !analog_ctrl.power_off && (pos_sel > neg_sel);
  end
endmodule // cmp_core_model

// ==== tb/cmp_ctrl_monitor.sv ====
// Concurrent checks on the ports of the comparator control block.
`timescale 1ns/1ns
module cmp_ctrl_monitor (
  input wire logic                          mclk,
  input wire logic                          srst,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_ack_o,
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          cmp_raw,
  input wire logic                          converter_enable,
  input wire logic                          cmp_pos_pin_read,
  input wire logic                          cmp_neg_pin_read,
  input wire cmp_ctrl_pkg::analog_ctrl_type analog_ctrl,
  input wire cmp_ctrl_pkg::route_type       route
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // A request is taken only while no answer is pending.
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cap_on;
    route.capture_route && $past(route.capture_route);
  endsequence
  sequence s_pin_on;
    route.pin_out_enable && $past(route.pin_out_enable);
  endsequence

  a_ack_answer: assert property (s_taken |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
  // The routed copy trails the raw result by the synchronizer plus one register.
  a_capture_path: assert property (s_cap_on |-> route.capture_in == $past(cmp_raw, 3))
    else $error("capture path wrong");
  a_capture_off: assert property (!route.capture_route |-> !route.capture_in)
    else $error("capture path open");
  a_pin_path: assert property (s_pin_on |-> route.pin_out == $past(cmp_raw, 3))
    else $error("pin path wrong");
  a_pin_off: assert property (!route.pin_out_enable |-> !route.pin_out)
    else $error("pin driven while off");
  a_hyst_level: assert property (!analog_ctrl.hyst_enable |-> !analog_ctrl.hyst_level_high)
    else $error("level without hysteresis");
  a_mux_select: assert property (analog_ctrl.neg_adc_mux |-> !$past(converter_enable))
    else $error("mux with converter on");
  a_neg_disable: assert property (analog_ctrl.neg_pin_input_disable &&
    $past(analog_ctrl.neg_pin_input_disable) |-> !cmp_neg_pin_read) else $error("neg pin read");
  a_pos_disable: assert property (analog_ctrl.pos_pin_input_disable &&
    $past(analog_ctrl.pos_pin_input_disable) |-> !cmp_pos_pin_read) else $error("pos pin read");
endmodule // cmp_ctrl_monitor

bind analog_comparator_control cmp_ctrl_monitor mon_u (.mclk(mclk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .cmp_raw(cmp_raw), .converter_enable(converter_enable), .cmp_pos_pin_read(cmp_pos_pin_read),
  .cmp_neg_pin_read(cmp_neg_pin_read), .analog_ctrl(analog_ctrl), .route(route));

// ==== tb/testbench.sv ====
// Self-checking bench for the comparator control block.
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] CTRL = cmp_ctrl_pkg::OFF_CTRL_STATUS;
  localparam logic [7:0] CFG  = cmp_ctrl_pkg::OFF_INPUT_CFG;
  localparam logic [7:0] DID  = cmp_ctrl_pkg::OFF_DIDR;
  localparam logic [7:0] STS  = cmp_ctrl_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] MSK  = cmp_ctrl_pkg::OFF_IRQ_MASK;
  localparam logic [7:0] EXT  = cmp_ctrl_pkg::OFF_CTRL_EXT;
  // Every mapped register plus one unmapped address, all zero after reset.
  localparam logic [7:0] RST_ADR [7] = '{CTRL, CFG, DID, STS, MSK, EXT, 8'hFC};
  logic                          mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                          cmp_raw, converter_enable, pos_pad, neg_pad, pos_rd, neg_rd;
  logic                          cmp_irq_request, irq;
  logic [7:0]                    wb_adr_i, rd, m;
  logic [3:0]                    wb_sel_i;
  logic [31:0]                   wb_dat_i, wb_dat_o;
  logic [15:0]                   pos_mv, neg_mv, mux_mv;
  cmp_ctrl_pkg::analog_ctrl_type analog_ctrl;
  cmp_ctrl_pkg::route_type       route;
  int                            fails = 0, samples_checked = 0, cycles = 0;

  analog_comparator_control dut_u (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_raw(cmp_raw),
    .converter_enable(converter_enable), .cmp_pos_pin_digital(pos_pad),
    .cmp_neg_pin_digital(neg_pad), .cmp_pos_pin_read(pos_rd), .cmp_neg_pin_read(neg_rd),
    .analog_ctrl(analog_ctrl), .route(route), .cmp_irq_request(cmp_irq_request), .irq(irq));
  cmp_core_model model_u (.analog_ctrl(analog_ctrl), .pos_mv(pos_mv), .neg_mv(neg_mv),
    .mux_mv(mux_mv), .cmp_raw(cmp_raw));

  // Clock generator, 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One classic cycle; entered just after an edge, leaves an idle cycle behind it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp, "register read");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {srst, pos_pad, neg_pad} = 3'b111;
    {wb_cyc_i, wb_stb_i, wb_we_i, converter_enable} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {pos_mv, neg_mv, mux_mv} = {16'd0, 16'd500, 16'd700};
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) rdchk(RST_ADR[i], 8'h00);
    bus(1'b1, 8'hFC, 8'hFF);
    rdchk(8'hFC, 8'h00);
    $display("test reset and unmapped done");
    bus(1'b1, CFG, 8'hFF);
    rdchk(CFG, 8'hD4);
    check(analog_ctrl[4:2], 3'b111, "mux and hysteresis");
    converter_enable <= 1'b1;
    repeat (2) @(posedge mclk);
    check(analog_ctrl.neg_adc_mux, 1'b0, "mux with converter on");
    converter_enable <= 1'b0;
    bus(1'b1, CFG, 8'h54);
    check(analog_ctrl[3:2], 2'b00, "hysteresis off");
    bus(1'b1, DID, 8'h18);
    rdchk(DID, 8'h18);
    check({pos_rd, neg_rd, analog_ctrl[1:0]}, 4'h3, "pins disabled");
    bus(1'b1, DID, 8'h00);
    check({pos_rd, neg_rd}, 2'b11, "pins enabled");
    $display("test input config done");
    // Each mode is set with the interrupt disabled, then a rise and a fall are applied.
    for (m = 8'h00; m < 8'h04; m++) begin
      bus(1'b1, CTRL, 8'h14 | m);
      bus(1'b1, STS, 8'h07);
      pos_mv <= 16'd1000;
      repeat (6) @(posedge mclk);
      rdchk(CTRL, 8'h24 | m | ((m == 8'h00 || m == 8'h03) ? 8'h10 : 8'h00));
      bus(1'b1, CTRL, 8'h14 | m);
      pos_mv <= 16'd0;
      repeat (6) @(posedge mclk);
      rdchk(CTRL, 8'h04 | m | ((m == 8'h00 || m == 8'h02) ? 8'h10 : 8'h00));
      rdchk(STS, {5'h00, m != 8'h01, 2'b11});
    end
    $display("test interrupt modes done");
    bus(1'b1, EXT, 8'h01);
    bus(1'b1, CTRL, 8'h1B);
    pos_mv <= 16'd1000;
    repeat (6) @(posedge mclk);
    check(cmp_irq_request, 1'b1, "request raised");
    check(irq, 1'b0, "masked event");
    bus(1'b1, EXT, 8'h03);
    rdchk(CTRL, 8'h2B);
    check(cmp_irq_request, 1'b0, "request after vector");
    bus(1'b1, CTRL, 8'h13);
    pos_mv <= 16'd0;
    repeat (4) @(posedge mclk);
    pos_mv <= 16'd1000;
    repeat (6) @(posedge mclk);
    rdchk(CTRL, 8'h33);
    check(cmp_irq_request, 1'b0, "request while disabled");
    bus(1'b1, CTRL, 8'h13);
    rdchk(CTRL, 8'h23);
    bus(1'b1, MSK, 8'h01);
    rdchk(MSK, 8'h01);
    check(irq, 1'b1, "unmasked event");
    bus(1'b1, STS, 8'h07);
    bus(1'b1, MSK, 8'h00);
    check(irq, 1'b0, "event cleared");
    $display("test interrupt path done");
    bus(1'b1, CTRL, 8'hC3);
    repeat (6) @(posedge mclk);
    check(analog_ctrl[6:5], 2'b11, "power and bandgap");
    rdchk(CTRL, 8'hC3);
    mux_mv <= 16'd1500;
    pos_mv <= 16'd2000;
    bus(1'b1, CTRL, 8'h43);
    repeat (6) @(posedge mclk);
    rdchk(CTRL, 8'h43);
    $display("test power and bandgap done");
    final_report();
  end
endmodule // testbench
